// file: logic/mads_pkg.sv
// Shared constants, operation codes and carriers of the ALU status datapath
package mads_pkg;

  // Direct addresses in the special-function space
  localparam logic [7:0] STAT_ADDR       = 8'hD0;
  localparam logic [7:0] MAIN_ADDR       = 8'hE0;
  localparam logic [7:0] MD_ADDR         = 8'hF0;

  // Values after reset
  localparam logic [7:0] STAT_RESET      = 8'h00;
  localparam logic [7:0] MAIN_RESET      = 8'h00;
  localparam logic [7:0] MD_RESET        = 8'h00;

  // Status word field positions
  localparam int         STAT_CARRY_BIT  = 7;
  localparam int         STAT_HALF_BIT   = 6;
  localparam int         STAT_UF0_BIT    = 5;
  localparam int         STAT_BANK_HI    = 4;
  localparam int         STAT_BANK_LO    = 3;
  localparam int         STAT_RANGE_BIT  = 2;
  localparam int         STAT_UF1_BIT    = 1;
  localparam int         STAT_PAR_BIT    = 0;

  // Working register bank: eight bytes per bank
  localparam int         BANK_SHIFT      = 3;

  // Decimal adjust thresholds and steps
  localparam logic [3:0] BCD_MAX_DIGIT   = 4'h9;
  localparam logic [7:0] BCD_LOW_STEP    = 8'h06;
  localparam logic [7:0] BCD_HIGH_STEP   = 8'h60;

  // Operations issued by the instruction decoder
  typedef enum logic [5:0] {
    OP_NOP      = 6'h00, OP_MOV      = 6'h01, OP_ADD      = 6'h02,
    OP_ADDC     = 6'h03, OP_SUBB     = 6'h04, OP_INC      = 6'h05,
    OP_DEC      = 6'h06, OP_MUL      = 6'h07, OP_DIV      = 6'h08,
    OP_DA       = 6'h09, OP_CMP      = 6'h0A, OP_ANL      = 6'h0B,
    OP_ORL      = 6'h0C, OP_XRL      = 6'h0D, OP_CPL      = 6'h0E,
    OP_CLR      = 6'h0F, OP_RL       = 6'h10, OP_RLC      = 6'h11,
    OP_RR       = 6'h12, OP_RRC      = 6'h13, OP_SWAP     = 6'h14,
    OP_C_SET    = 6'h15, OP_C_CLR    = 6'h16, OP_C_CPL    = 6'h17,
    OP_BIT_SET  = 6'h18, OP_BIT_CLR  = 6'h19, OP_BIT_CPL  = 6'h1A,
    OP_JB       = 6'h1B, OP_JNB      = 6'h1C, OP_JBC      = 6'h1D,
    OP_MOV_CB   = 6'h1E, OP_MOV_BC   = 6'h1F, OP_ANL_CB   = 6'h20,
    OP_ORL_CB   = 6'h21, OP_ANL_CNB  = 6'h22, OP_ORL_CNB  = 6'h23
  } mads_op_e;

  // One operation request from the decoder
  typedef struct packed {
    logic       valid;
    mads_op_e   op;
    logic [7:0] operand;
    logic       bit_val;
  } mads_req_s;

  // One direct-address access
  typedef struct packed {
    logic [7:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } mads_acc_s;

endpackage : mads_pkg

// file: logic/mads_muldiv.sv
// Single-cycle 8x8 multiplier and 8/8 restoring divider
`timescale 1ns/10ps
module mads_muldiv (
  input  wire logic [7:0]  left_in,
  input  wire logic [7:0]  right_in,
  output logic      [15:0] prod_out,
  output logic      [7:0]  quot_out,
  output logic      [7:0]  rem_out,
  output logic             div_zero_out
);

  logic [8:0] part;

  // Product of the two operands
  assign prod_out     = 16'(left_in) * 16'(right_in);
  assign div_zero_out = (right_in == 8'h00);

  // Restoring division, one quotient bit per step
  always_comb begin
    part     = 9'h000;
    quot_out = 8'h00;
    rem_out  = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      part = {rem_out, left_in[i]};
      if (part >= {1'b0, right_in}) begin
        part        = part - {1'b0, right_in};
        quot_out[i] = 1'b1;
      end
      rem_out = part[7:0];
    end
  end

endmodule : mads_muldiv

// file: logic/mads_bitproc.sv
// Boolean processor: single-bit operations on the carry and a selected bit
`timescale 1ns/10ps
module mads_bitproc (
  input  wire mads_pkg::mads_op_e op_in,
  input  wire logic               carry_in,
  input  wire logic               bit_in,
  output logic                    carry_nxt_out,
  output logic                    carry_we_out,
  output logic                    bit_nxt_out,
  output logic                    bit_we_out,
  output logic                    branch_out
);

  // Decode of the bit operations; anything else leaves both bits alone
  always_comb begin
    carry_nxt_out = carry_in;
    carry_we_out  = 1'b0;
    bit_nxt_out   = bit_in;
    bit_we_out    = 1'b0;
    branch_out    = 1'b0;
    case (op_in)
      mads_pkg::OP_C_SET: begin
        carry_nxt_out = 1'b1;
        carry_we_out  = 1'b1;
      end
      mads_pkg::OP_C_CLR: begin
        carry_nxt_out = 1'b0;
        carry_we_out  = 1'b1;
      end
      mads_pkg::OP_C_CPL: begin
        carry_nxt_out = ~carry_in;
        carry_we_out  = 1'b1;
      end
      mads_pkg::OP_BIT_SET: begin
        bit_nxt_out = 1'b1;
        bit_we_out  = 1'b1;
      end
      mads_pkg::OP_BIT_CLR: begin
        bit_nxt_out = 1'b0;
        bit_we_out  = 1'b1;
      end
      mads_pkg::OP_BIT_CPL: begin
        bit_nxt_out = ~bit_in;
        bit_we_out  = 1'b1;
      end
      mads_pkg::OP_JB:  branch_out = bit_in;
      mads_pkg::OP_JNB: branch_out = ~bit_in;
      mads_pkg::OP_JBC: begin
        branch_out  = bit_in;
        bit_nxt_out = 1'b0;        // Clear only when the jump is taken
        bit_we_out  = bit_in;
      end
      mads_pkg::OP_MOV_CB: begin
        carry_nxt_out = bit_in;
        carry_we_out  = 1'b1;
      end
      mads_pkg::OP_MOV_BC: begin
        bit_nxt_out = carry_in;
        bit_we_out  = 1'b1;
      end
      mads_pkg::OP_ANL_CB: begin
        carry_nxt_out = carry_in & bit_in;
        carry_we_out  = 1'b1;
      end
      mads_pkg::OP_ORL_CB: begin
        carry_nxt_out = carry_in | bit_in;
        carry_we_out  = 1'b1;
      end
      mads_pkg::OP_ANL_CNB: begin
        carry_nxt_out = carry_in & ~bit_in;
        carry_we_out  = 1'b1;
      end
      mads_pkg::OP_ORL_CNB: begin
        carry_nxt_out = carry_in | ~bit_in;
        carry_we_out  = 1'b1;
      end
      default: ;
    endcase
  end

endmodule : mads_bitproc

// file: logic/mads_datapath.sv
// ALU datapath with main operand, multiply/divide operand and status word
//
// Notes on behaviour
// [RULE1] All arithmetic and logic works on 8-bit byte operands.
// [RULE2] The main operand register sits at 0xE0, is 8 bits and resets to 0.
// [RULE3] The register at 0xF0 feeds and takes multiply/divide, else is plain.
// [RULE4] The status word at 0xD0 holds carry..parity from bit 7 down, reset 0.
// [RULE5] The bank select bits place R0-R7 at 0x00, 0x08, 0x10 or 0x18.
// [RULE6] Add, subtract, multiply, divide, inc, dec, decimal adjust, compare.
// [RULE7] Bytewise AND, OR, XOR, complement and rotates.
// [RULE8] Bit set, clear, complement, jump if clear, jump and clear, carry move.
// [RULE9] Each direct address can be read, written and read-modify-written.
// [RULE10] Each operation gives the standard 8051 result and flags.
// [RULE11] The parity bit always shows odd parity of the main operand.
// [RULE12] Carry, half carry and range error follow the usual 8051 rules.
`timescale 1ns/10ps
module mads_datapath (
  input  wire logic                clock_in,
  input  wire logic                nrst_in,
  input  wire mads_pkg::mads_req_s req_in,
  input  wire mads_pkg::mads_acc_s access_in,
  input  wire logic [7:0]          ext_rdata_in,
  output logic                     ext_sel_out,
  output logic [7:0]               rdata_out,
  output logic [7:0]               main_out,
  output logic [7:0]               md_out,
  output logic [7:0]               status_out,
  output logic [7:0]               bank_base_out,
  output logic                     branch_out,
  output logic                     bit_out,
  output logic                     bit_we_out
);

  logic [7:0]  main_r,     main_nxt;
  logic [7:0]  md_r,       md_nxt;
  logic [7:1]  status_r,   status_nxt;
  logic [7:0]  rdata_r,    rdata_nxt;
  logic        branch_r,   branch_nxt;
  logic        bit_r;
  logic        bit_we_r;
  logic        carry_nxt,  half_nxt,  range_nxt;
  logic        arith_we,   half_we,   range_we;
  logic [8:0]  wide;
  logic [4:0]  nib;
  logic [7:0]  opnd;
  logic        cin;
  logic        parity;
  logic        is_stat,    is_main,   is_md;
  logic        alu_go;
  logic [15:0] prod;
  logic [7:0]  quot,       rem;
  logic        div_zero;
  logic        bp_carry,   bp_carry_we, bp_bit, bp_bit_we, bp_branch;

  // Address decode of the three local registers
  assign is_stat     = (access_in.addr == mads_pkg::STAT_ADDR);
  assign is_main     = (access_in.addr == mads_pkg::MAIN_ADDR);
  assign is_md       = (access_in.addr == mads_pkg::MD_ADDR);
  assign ext_sel_out = ~(is_stat | is_main | is_md);       // [RULE9]
  assign alu_go      = req_in.valid;
  assign opnd        = req_in.operand;
  assign cin         = status_r[mads_pkg::STAT_CARRY_BIT];

  // Parity tracks the register continuously
  assign parity        = ^main_r;                                // [RULE11]
  assign status_out    = {status_r, parity};                     // [RULE4]
  assign bank_base_out = {6'h00, status_r[mads_pkg::STAT_BANK_HI:
                                          mads_pkg::STAT_BANK_LO]}
                         << mads_pkg::BANK_SHIFT;                // [RULE5]
  assign main_out      = main_r;
  assign md_out        = md_r;
  assign rdata_out     = rdata_r;
  assign branch_out    = branch_r;
  assign bit_out       = bit_r;
  assign bit_we_out    = bit_we_r;

  mads_muldiv u_muldiv (
    .left_in      (main_r),
    .right_in     (md_r),
    .prod_out     (prod),
    .quot_out     (quot),
    .rem_out      (rem),
    .div_zero_out (div_zero)
  );

  mads_bitproc u_bitproc (
    .op_in         (req_in.op),
    .carry_in      (cin),
    .bit_in        (req_in.bit_val),
    .carry_nxt_out (bp_carry),
    .carry_we_out  (bp_carry_we),
    .bit_nxt_out   (bp_bit),
    .bit_we_out    (bp_bit_we),
    .branch_out    (bp_branch)
  );

  // Byte operations and their flag effects
  always_comb begin
    main_nxt   = main_r;
    md_nxt     = md_r;
    carry_nxt  = cin;
    half_nxt   = status_r[mads_pkg::STAT_HALF_BIT];
    range_nxt  = status_r[mads_pkg::STAT_RANGE_BIT];
    arith_we   = 1'b0;
    half_we    = 1'b0;
    range_we   = 1'b0;
    branch_nxt = 1'b0;
    wide       = 9'h000;
    nib        = 5'h00;
    case (req_in.op)                                             // [RULE10]
      mads_pkg::OP_MOV: main_nxt = opnd;
      mads_pkg::OP_ADD, mads_pkg::OP_ADDC: begin                 // [RULE6]
        wide = {1'b0, main_r} + {1'b0, opnd}
             + {8'h00, cin & (req_in.op == mads_pkg::OP_ADDC)};
        nib  = {1'b0, main_r[3:0]} + {1'b0, opnd[3:0]}
             + {4'h0, cin & (req_in.op == mads_pkg::OP_ADDC)};
        main_nxt  = wide[7:0];
        carry_nxt = wide[8];                                     // [RULE12]
        half_nxt  = nib[4];
        range_nxt = (main_r[7] == opnd[7]) && (wide[7] != main_r[7]);
        arith_we  = 1'b1;
        half_we   = 1'b1;
        range_we  = 1'b1;
      end
      mads_pkg::OP_SUBB: begin                                   // [RULE6]
        wide = {1'b0, main_r} - {1'b0, opnd} - {8'h00, cin};
        nib  = {1'b0, main_r[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cin};
        main_nxt  = wide[7:0];
        carry_nxt = wide[8];                                     // [RULE12]
        half_nxt  = nib[4];
        range_nxt = (main_r[7] != opnd[7]) && (wide[7] != main_r[7]);
        arith_we  = 1'b1;
        half_we   = 1'b1;
        range_we  = 1'b1;
      end
      mads_pkg::OP_INC: main_nxt = main_r + 8'h01;               // [RULE6]
      mads_pkg::OP_DEC: main_nxt = main_r - 8'h01;
      mads_pkg::OP_MUL: begin                                    // [RULE3]
        main_nxt  = prod[7:0];
        md_nxt    = prod[15:8];
        carry_nxt = 1'b0;
        range_nxt = (prod[15:8] != 8'h00);
        arith_we  = 1'b1;
        range_we  = 1'b1;
      end
      mads_pkg::OP_DIV: begin                                    // [RULE3]
        if (!div_zero) begin
          main_nxt = quot;
          md_nxt   = rem;
        end
        carry_nxt = 1'b0;
        range_nxt = div_zero;                // Divide by zero flags range
        arith_we  = 1'b1;
        range_we  = 1'b1;
      end
      mads_pkg::OP_DA: begin                                     // [RULE6]
        wide = {1'b0, main_r};
        if (main_r[3:0] > mads_pkg::BCD_MAX_DIGIT ||
            status_r[mads_pkg::STAT_HALF_BIT])
          wide = wide + {1'b0, mads_pkg::BCD_LOW_STEP};
        if (wide[7:4] > mads_pkg::BCD_MAX_DIGIT || wide[8] || cin)
          wide = {1'b1, wide[7:0] + mads_pkg::BCD_HIGH_STEP};
        main_nxt  = wide[7:0];
        carry_nxt = cin | wide[8];           // Adjust only ever sets carry
        arith_we  = 1'b1;
      end
      mads_pkg::OP_CMP: begin                                    // [RULE6]
        carry_nxt  = (main_r < opnd);
        arith_we   = 1'b1;
        branch_nxt = (main_r != opnd);
      end
      mads_pkg::OP_ANL:  main_nxt = main_r & opnd;               // [RULE7]
      mads_pkg::OP_ORL:  main_nxt = main_r | opnd;
      mads_pkg::OP_XRL:  main_nxt = main_r ^ opnd;
      mads_pkg::OP_CPL:  main_nxt = ~main_r;
      mads_pkg::OP_CLR:  main_nxt = 8'h00;
      mads_pkg::OP_RL:   main_nxt = {main_r[6:0], main_r[7]};
      mads_pkg::OP_RR:   main_nxt = {main_r[0], main_r[7:1]};
      mads_pkg::OP_SWAP: main_nxt = {main_r[3:0], main_r[7:4]};
      mads_pkg::OP_RLC: begin
        main_nxt  = {main_r[6:0], cin};
        carry_nxt = main_r[7];
        arith_we  = 1'b1;
      end
      mads_pkg::OP_RRC: begin
        main_nxt  = {cin, main_r[7:1]};
        carry_nxt = main_r[0];
        arith_we  = 1'b1;
      end
      default: begin                                             // [RULE8]
        carry_nxt  = bp_carry;
        arith_we   = bp_carry_we;
        branch_nxt = bp_branch;
      end
    endcase
  end

  // Status word: a direct write lands first, operation flags win over it
  always_comb begin
    status_nxt = status_r;
    if (access_in.wr && is_stat)
      status_nxt = access_in.wdata[7:1];                         // [RULE4]
    if (alu_go && arith_we)
      status_nxt[mads_pkg::STAT_CARRY_BIT] = carry_nxt;          // [RULE12]
    if (alu_go && half_we)
      status_nxt[mads_pkg::STAT_HALF_BIT] = half_nxt;
    if (alu_go && range_we)
      status_nxt[mads_pkg::STAT_RANGE_BIT] = range_nxt;
  end

  // Read data of the addressed register, outside addresses pass through
  always_comb begin
    rdata_nxt = rdata_r;
    if (access_in.rd) begin                                      // [RULE9]
      if (is_main)
        rdata_nxt = main_r;
      else if (is_md)
        rdata_nxt = md_r;
      else if (is_stat)
        rdata_nxt = status_out;
      else
        rdata_nxt = ext_rdata_in;
    end
  end

  // Main operand register; an operation beats a direct write
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in)
      main_r <= mads_pkg::MAIN_RESET;                            // [RULE2]
    else if (alu_go)
      main_r <= main_nxt;                                        // [RULE1]
    else if (access_in.wr && is_main)
      main_r <= access_in.wdata;                                 // [RULE2]
  end

  // Multiply/divide operand register, plain storage otherwise
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in)
      md_r <= mads_pkg::MD_RESET;                                // [RULE3]
    else if (alu_go && (req_in.op == mads_pkg::OP_MUL ||
                        req_in.op == mads_pkg::OP_DIV))
      md_r <= md_nxt;                                            // [RULE3]
    else if (access_in.wr && is_md)
      md_r <= access_in.wdata;                                   // [RULE3]
  end

  // Status word storage; parity is never stored
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in)
      status_r <= mads_pkg::STAT_RESET[7:1];                     // [RULE4]
    else
      status_r <= status_nxt;
  end

  // Read data, branch decision and bit result
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_r  <= 8'h00;
      branch_r <= 1'b0;
      bit_r    <= 1'b0;
      bit_we_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      branch_r <= alu_go & branch_nxt;                           // [RULE8]
      bit_r    <= bp_bit;
      bit_we_r <= alu_go & bp_bit_we;                            // [RULE8]
    end
  end

  // Checks on the datapath
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  parity_tracks_a: assert property (status_out[0] == ^main_out) // [RULE11]
    else $error("parity bit disagrees with main operand");
  bank_base_a: assert property (
    bank_base_out == {3'b000, status_out[4:3], 3'b000})         // [RULE5]
    else $error("bank base does not follow bank select");
  add_result_a: assert property (                               // [RULE12]
    req_in.valid && req_in.op == mads_pkg::OP_ADD
    |=> {status_out[7], main_out} ==
        $past({1'b0, main_r} + {1'b0, req_in.operand}))
    else $error("add result or carry wrong");
  subb_range_a: assert property (                               // [RULE12]
    req_in.valid && req_in.op == mads_pkg::OP_SUBB &&
    main_r == 8'h80 && req_in.operand == 8'h01 && !cin
    |=> status_out[2] && main_out == 8'h7F && !status_out[7])
    else $error("subtract overflow wrong");
  mul_result_a: assert property (                               // [RULE6]
    req_in.valid && req_in.op == mads_pkg::OP_MUL
    |=> {md_out, main_out} == $past(main_r) * $past(md_r))
    else $error("multiply result wrong");
  div_result_a: assert property (                               // [RULE6]
    req_in.valid && req_in.op == mads_pkg::OP_DIV && md_r != 8'h00
    |=> main_out == $past(main_r) / $past(md_r) &&
        md_out == $past(main_r) % $past(md_r) && !status_out[2])
    else $error("divide result wrong");
  xor_result_a: assert property (                               // [RULE7]
    req_in.valid && req_in.op == mads_pkg::OP_XRL
    |=> main_out == ($past(main_r) ^ $past(req_in.operand)))
    else $error("exclusive or result wrong");
  jbc_clear_a: assert property (                                // [RULE8]
    req_in.valid && req_in.op == mads_pkg::OP_JBC && req_in.bit_val
    |=> branch_out && bit_we_out && !bit_out
        ##1 (!branch_out || $past(req_in.valid)))
    else $error("jump and clear misbehaved");
  main_write_a: assert property (                               // [RULE2]
    !req_in.valid && access_in.wr && access_in.addr == 8'hE0
    |=> main_out == $past(access_in.wdata))
    else $error("main operand write lost");
  md_write_a: assert property (                                 // [RULE3]
    !req_in.valid && access_in.wr && access_in.addr == 8'hF0
    |=> md_out == $past(access_in.wdata))
    else $error("multiply/divide operand write lost");
  stat_read_a: assert property (                                // [RULE9]
    access_in.rd && access_in.addr == 8'hD0
    |=> rdata_out == $past(status_out))
    else $error("status read data wrong");

  add_carry_c: cover property (
    req_in.valid && req_in.op == mads_pkg::OP_ADDC ##1 status_out[7]);
  div_zero_c: cover property (
    req_in.valid && req_in.op == mads_pkg::OP_DIV && md_r == 8'h00);
  rmw_c: cover property (
    access_in.rd && is_md ##2 access_in.wr && is_md);

endmodule : mads_datapath

// file: tb/mads_tb_top.sv
// Self-checking bench for the ALU status datapath
`timescale 1ns/10ps
module tb_top;
  logic                clock_in;
  logic                nrst_in;
  mads_pkg::mads_req_s req;
  mads_pkg::mads_acc_s acc;
  logic [7:0]          ext_rdata;
  logic                ext_sel;
  logic [7:0]          rdata;
  logic [7:0]          main_q;
  logic [7:0]          md_q;
  logic [7:0]          stat;
  logic [7:0]          bank_base;
  logic                br;
  logic                bit_q;
  logic                bit_we;
  logic [2:0]          pulse;
  logic [7:0]          got;
  logic [7:0]          regs [3];
  int                  failures;
  int                  tests_run;

  mads_datapath i_dut (
    .clock_in      (clock_in),
    .nrst_in       (nrst_in),
    .req_in        (req),
    .access_in     (acc),
    .ext_rdata_in  (ext_rdata),
    .ext_sel_out   (ext_sel),
    .rdata_out     (rdata),
    .main_out      (main_q),
    .md_out        (md_q),
    .status_out    (stat),
    .bank_base_out (bank_base),
    .branch_out    (br),
    .bit_out       (bit_q),
    .bit_we_out    (bit_we)
  );

  // Core clock, 40 ns period
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // Compare one value and count any mismatch
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic tally_and_finish();
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // One operation, then an idle cycle; pulses are caught after the first edge
  task automatic go(input mads_pkg::mads_op_e code, input logic [7:0] opd,
                    input logic bv, input logic [7:0] em, input logic ec);
    req = '{1'b1, code, opd, bv};
    @(posedge clock_in);
    #1;
    pulse = {br, bit_we, bit_q};
    req.valid = 1'b0;
    @(posedge clock_in);
    #1;
    check("main", main_q, em);
    check("carry", {7'h00, stat[7]}, {7'h00, ec});
  endtask : go

  // Direct-address write, one edge wide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc = '{a, 1'b0, 1'b1, d};
    @(posedge clock_in);
    #1;
    acc.wr = 1'b0;
    @(posedge clock_in);
    #1;
  endtask : wr

  // Direct-address read, data taken after the edge
  task automatic rd(input logic [7:0] a);
    acc = '{a, 1'b1, 1'b0, 8'h00};
    @(posedge clock_in);
    #1;
    got = rdata;
    acc.rd = 1'b0;
    @(posedge clock_in);
    #1;
  endtask : rd

  // Cuts a hung run short
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    nrst_in = 1'b0;
    req = '0;
    acc = '0;
    ext_rdata = 8'hA5;
    failures = 0;
    tests_run = 0;
    regs = '{mads_pkg::STAT_ADDR, mads_pkg::MAIN_ADDR, mads_pkg::MD_ADDR};
    repeat (4) @(posedge clock_in);
    #1;
    nrst_in = 1'b1;
    check("main rst", main_q, mads_pkg::MAIN_RESET);
    check("md rst", md_q, mads_pkg::MD_RESET);
    check("stat rst", stat, mads_pkg::STAT_RESET);
    for (int i = 0; i < 3; i++) begin
      rd(regs[i]);
      check("read rst", got, 8'h00);
      wr(regs[i], 8'h5A);
    end
    for (int i = 0; i < 3; i++) begin
      rd(regs[i]);
      check("read back", got, 8'h5A);
    end
    wr(mads_pkg::STAT_ADDR, 8'h01);
    check("parity wr", stat, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(mads_pkg::STAT_ADDR, 8'(k * 8));
      check("bank", bank_base, 8'(k * 8));
    end
    wr(mads_pkg::MAIN_ADDR, 8'h07);
    check("parity", {7'h00, stat[0]}, 8'h01);
    rd(mads_pkg::MD_ADDR);
    wr(mads_pkg::MD_ADDR, got ^ 8'hFF);
    check("rmw", md_q, 8'hA5);
    check("sel own", {7'h00, ext_sel}, 8'h00);
    rd(8'h80);
    check("sel ext", {7'h00, ext_sel}, 8'h01);
    check("ext read", got, 8'hA5);
    wr(mads_pkg::MAIN_ADDR, 8'h7F);
    go(mads_pkg::OP_ADD, 8'h01, 1'b0, 8'h80, 1'b0);
    check("ac ov", {6'h00, stat[6], stat[2]}, 8'h03);
    go(mads_pkg::OP_ADD, 8'h80, 1'b0, 8'h00, 1'b1);
    check("ac ov", {6'h00, stat[6], stat[2]}, 8'h01);
    go(mads_pkg::OP_ADDC, 8'h01, 1'b0, 8'h02, 1'b0);
    go(mads_pkg::OP_SUBB, 8'h03, 1'b0, 8'hFF, 1'b1);
    check("ac ov", {6'h00, stat[6], stat[2]}, 8'h02);
    go(mads_pkg::OP_SUBB, 8'h7F, 1'b0, 8'h7F, 1'b0);
    check("ac ov", {6'h00, stat[6], stat[2]}, 8'h03);
    go(mads_pkg::OP_MOV, 8'h80, 1'b0, 8'h80, 1'b0);
    go(mads_pkg::OP_SUBB, 8'h01, 1'b0, 8'h7F, 1'b0);
    check("sub ov", {6'h00, stat[6], stat[2]}, 8'h03);
    go(mads_pkg::OP_C_SET, 8'h00, 1'b0, 8'h7F, 1'b1);
    go(mads_pkg::OP_INC, 8'h00, 1'b0, 8'h80, 1'b1);
    go(mads_pkg::OP_DEC, 8'h00, 1'b0, 8'h7F, 1'b1);
    wr(mads_pkg::MD_ADDR, 8'h10);
    go(mads_pkg::OP_MOV, 8'h20, 1'b0, 8'h20, 1'b1);
    go(mads_pkg::OP_MUL, 8'h00, 1'b0, 8'h00, 1'b0);
    check("mul hi", md_q, 8'h02);
    check("mul ov", {7'h00, stat[2]}, 8'h01);
    wr(mads_pkg::MD_ADDR, 8'h0A);
    go(mads_pkg::OP_MOV, 8'hFB, 1'b0, 8'hFB, 1'b0);
    go(mads_pkg::OP_DIV, 8'h00, 1'b0, 8'h19, 1'b0);
    check("div rem", md_q, 8'h01);
    check("div ov", {7'h00, stat[2]}, 8'h00);
    wr(mads_pkg::MD_ADDR, 8'h00);
    go(mads_pkg::OP_C_SET, 8'h00, 1'b0, 8'h19, 1'b1);
    go(mads_pkg::OP_DIV, 8'h00, 1'b0, 8'h19, 1'b0);
    check("div0 ov", {7'h00, stat[2]}, 8'h01);
    go(mads_pkg::OP_MOV, 8'h15, 1'b0, 8'h15, 1'b0);
    go(mads_pkg::OP_ADD, 8'h27, 1'b0, 8'h3C, 1'b0);
    go(mads_pkg::OP_DA, 8'h00, 1'b0, 8'h42, 1'b0);
    go(mads_pkg::OP_MOV, 8'h99, 1'b0, 8'h99, 1'b0);
    go(mads_pkg::OP_ADD, 8'h99, 1'b0, 8'h32, 1'b1);
    go(mads_pkg::OP_DA, 8'h00, 1'b0, 8'h98, 1'b1);
    go(mads_pkg::OP_MOV, 8'h42, 1'b0, 8'h42, 1'b1);
    go(mads_pkg::OP_CMP, 8'h50, 1'b0, 8'h42, 1'b1);
    check("cmp br", {5'h00, pulse}, 8'h04);
    go(mads_pkg::OP_CMP, 8'h42, 1'b0, 8'h42, 1'b0);
    check("cmp eq", {5'h00, pulse}, 8'h00);
    go(mads_pkg::OP_MOV, 8'hF0, 1'b0, 8'hF0, 1'b0);
    go(mads_pkg::OP_ANL, 8'h3C, 1'b0, 8'h30, 1'b0);
    go(mads_pkg::OP_ORL, 8'h0F, 1'b0, 8'h3F, 1'b0);
    go(mads_pkg::OP_XRL, 8'hFF, 1'b0, 8'hC0, 1'b0);
    go(mads_pkg::OP_CPL, 8'h00, 1'b0, 8'h3F, 1'b0);
    go(mads_pkg::OP_RL, 8'h00, 1'b0, 8'h7E, 1'b0);
    go(mads_pkg::OP_RR, 8'h00, 1'b0, 8'h3F, 1'b0);
    go(mads_pkg::OP_SWAP, 8'h00, 1'b0, 8'hF3, 1'b0);
    go(mads_pkg::OP_CLR, 8'h00, 1'b0, 8'h00, 1'b0);
    go(mads_pkg::OP_C_SET, 8'h00, 1'b0, 8'h00, 1'b1);
    go(mads_pkg::OP_RLC, 8'h00, 1'b0, 8'h01, 1'b0);
    go(mads_pkg::OP_RRC, 8'h00, 1'b0, 8'h00, 1'b1);
    go(mads_pkg::OP_C_CLR, 8'h00, 1'b0, 8'h00, 1'b0);
    go(mads_pkg::OP_C_CPL, 8'h00, 1'b0, 8'h00, 1'b1);
    go(mads_pkg::OP_JB, 8'h00, 1'b1, 8'h00, 1'b1);
    check("jb", {5'h00, pulse}, 8'h05);
    go(mads_pkg::OP_JNB, 8'h00, 1'b1, 8'h00, 1'b1);
    check("jnb set", {5'h00, pulse}, 8'h01);
    go(mads_pkg::OP_JNB, 8'h00, 1'b0, 8'h00, 1'b1);
    check("jnb", {5'h00, pulse}, 8'h04);
    go(mads_pkg::OP_JBC, 8'h00, 1'b1, 8'h00, 1'b1);
    check("jbc", {5'h00, pulse}, 8'h06);
    go(mads_pkg::OP_BIT_SET, 8'h00, 1'b0, 8'h00, 1'b1);
    check("setb", {5'h00, pulse}, 8'h03);
    go(mads_pkg::OP_BIT_CLR, 8'h00, 1'b1, 8'h00, 1'b1);
    check("clrb", {5'h00, pulse}, 8'h02);
    go(mads_pkg::OP_BIT_CPL, 8'h00, 1'b0, 8'h00, 1'b1);
    check("cplb", {5'h00, pulse}, 8'h03);
    go(mads_pkg::OP_MOV_BC, 8'h00, 1'b0, 8'h00, 1'b1);
    check("movbc", {5'h00, pulse}, 8'h03);
    go(mads_pkg::OP_MOV_CB, 8'h00, 1'b0, 8'h00, 1'b0);
    go(mads_pkg::OP_ORL_CB, 8'h00, 1'b1, 8'h00, 1'b1);
    go(mads_pkg::OP_ANL_CB, 8'h00, 1'b0, 8'h00, 1'b0);
    go(mads_pkg::OP_ORL_CNB, 8'h00, 1'b0, 8'h00, 1'b1);
    go(mads_pkg::OP_ANL_CNB, 8'h00, 1'b1, 8'h00, 1'b0);
    tally_and_finish();
  end
endmodule : tb_top
